// ---- src/eeprom_slave.v ----
// two-wire serial eeprom slave: addressing, acknowledge, writes, reads
// assumes scl and sda arrive asynchronously and sda is open drain
`timescale 1ns/1ps
`include "eeprom_slave_regs.vh"

// ****************************************************
// page buffer fifo
// ****************************************************
module page_fifo #(
	parameter W     = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire         i_flush,
	input  wire         i_valid,
	output wire         o_ready,
	input  wire [W-1:0] i_data,
	output wire         o_valid,
	input  wire         i_ready,
	output wire [W-1:0] o_data
);
	reg [W-1:0] buf_mem [0:DEPTH-1];
	reg [AW-1:0] wptr;
	reg [AW-1:0] rptr;
	reg [AW:0]   count;
	wire         push;
	wire         pop;
	assign o_ready = (count != DEPTH);
	assign o_valid = (count != 0);
	assign o_data  = buf_mem[rptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always @(posedge i_clk)
		if (push)
			buf_mem[wptr] <= i_data;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (i_flush) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // page_fifo

// ****************************************************
// slave access logic
// ****************************************************
module eeprom_slave #(
	parameter WR_CYCLES = `WR_CYCLES
) (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_scl,
	input  wire i_sda,
	output reg  o_sda,
	output reg  o_sda_oe,
	input  wire i_write_protect_pin,
	input  wire i_chip_select_mode,
	input  wire i_chip_select_pin2,
	input  wire i_chip_select_pin1,
	input  wire i_chip_select_pin0,
	output reg  o_busy
);
	localparam S_IDLE = 3'h0;
	localparam S_RX   = 3'h1;
	localparam S_ACK  = 3'h2;
	localparam S_TX   = 3'h3;
	localparam S_MACK = 3'h4;
	localparam S_WAIT = 3'h5;
	localparam K_DEV  = 2'h0;
	localparam K_WAHI = 2'h1;
	localparam K_WALO = 2'h2;
	localparam K_DATA = 2'h3;
	reg [7:0] mem [0:`MEM_WORDS-1];

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	reg [6:0] meta;
	reg [6:0] syn;
	reg       scl_d;
	reg       sda_d;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta  <= 7'h7F;
			syn   <= 7'h7F;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			meta  <= {i_scl, i_sda, i_write_protect_pin, i_chip_select_mode,
				i_chip_select_pin2, i_chip_select_pin1, i_chip_select_pin0};
			syn   <= meta;
			scl_d <= syn[6];
			sda_d <= syn[5];
		end
	end

	wire       scl     = syn[6];
	wire       sda     = syn[5];
	wire       wp      = syn[4];
	wire       cs_mode = syn[3];
	wire [2:0] cs_pins = syn[2:0];
	wire       scl_up  = scl && !scl_d;
	wire       scl_dn  = !scl && scl_d;
	wire       start   = scl && scl_d && sda_d && !sda;
	wire       stop    = scl && scl_d && !sda_d && sda;

	// ****************************************************
	// protocol engine
	// ****************************************************
	reg [2:0]         state;
	reg [1:0]         kind;
	reg [3:0]         bit_cnt;
	reg [7:0]         shreg;
	reg [7:0]         tx_byte;
	reg               rd_mode;
	reg               m_ack;
	reg [2:0]         addr_hi;
	reg [`ADDR_W-1:0] addr_cnt;
	reg [`ADDR_W-1:0] wr_addr;
	reg               wr_seen;
	reg [17:0]        wr_timer;
	reg               fifo_push;
	reg [`FIFO_W-1:0] fifo_din;
	wire              fifo_valid;
	wire [`FIFO_W-1:0] fifo_dout;
	wire              flush = start && !o_busy;

	// matching address byte, chip pins only compared in chip-select mode
	function dev_match(input [7:0] b, input mode, input [2:0] pins);
		dev_match = (b[7:4] == `DEV_TYPE) && (!mode || b[3:1] == pins);
	endfunction

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= S_IDLE;
			kind      <= K_DEV;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			tx_byte   <= 8'h00;
			rd_mode   <= 1'b0;
			m_ack     <= 1'b0;
			addr_hi   <= 3'h0;
			addr_cnt  <= {`ADDR_W{1'b0}};
			wr_addr   <= {`ADDR_W{1'b0}};
			wr_seen   <= 1'b0;
			fifo_push <= 1'b0;
			fifo_din  <= {`FIFO_W{1'b0}};
			o_sda     <= 1'b0;
			o_sda_oe  <= 1'b0;
		end else begin
			fifo_push <= 1'b0;
			if (start) begin // address byte follows directly
				state    <= S_RX;
				kind     <= K_DEV;
				bit_cnt  <= 4'h0;
				wr_seen  <= 1'b0;
				o_sda_oe <= 1'b0;
			end else if (stop) begin
				state    <= S_IDLE;
				o_sda_oe <= 1'b0;
			end else if (scl_up) begin
				if (state == S_RX || state == S_TX) begin
					shreg   <= {shreg[6:0], sda};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (state == S_MACK) begin
					m_ack    <= !sda;
					// counter moves past every word sent
					addr_cnt <= addr_cnt + 1'b1;
					tx_byte  <= mem[addr_cnt + 1'b1];
				end
			end else if (scl_dn) begin
				case (state)
				S_RX: begin
					if (bit_cnt == 4'h8) begin
						state    <= S_ACK;
						o_sda_oe <= 1'b1;
						case (kind)
						K_DEV: begin
							if (dev_match(shreg, cs_mode, cs_pins)
								&& !o_busy) begin
								rd_mode <= shreg[0];
								addr_hi <= shreg[3:1];
								tx_byte <= mem[addr_cnt];
								kind    <= cs_mode ? K_WAHI : K_WALO;
							end else begin
								state    <= S_WAIT;
								o_sda_oe <= 1'b0;
							end
						end
						K_WAHI: begin
							addr_hi <= shreg[2:0];
							kind    <= K_WALO;
						end
						K_WALO: begin
							addr_cnt <= {addr_hi, shreg};
							wr_addr  <= {addr_hi, shreg};
							kind     <= K_DATA;
						end
						default: begin
							// buffered unless write protected, programmed only at stop
							fifo_push <= !wp;
							fifo_din  <= {wr_addr, shreg};
							wr_seen   <= 1'b1;
							addr_cnt  <= wr_addr;
							wr_addr[`PAGE_BITS-1:0] <=
								wr_addr[`PAGE_BITS-1:0] + 1'b1;
						end
						endcase
					end
				end
				S_ACK: begin
					bit_cnt <= 4'h0;
					if (rd_mode) begin
						state    <= S_TX;
						o_sda_oe <= !tx_byte[7];
					end else begin
						state    <= S_RX;
						o_sda_oe <= 1'b0;
					end
				end
				S_TX: begin
					if (bit_cnt == 4'h8) begin
						state    <= S_MACK;
						o_sda_oe <= 1'b0;
					end else begin
						o_sda_oe <= !tx_byte[3'h7 - bit_cnt[2:0]];
					end
				end
				S_MACK: begin
					bit_cnt <= 4'h0;
					if (m_ack) begin
						state    <= S_TX;
						o_sda_oe <= !tx_byte[7];
					end else begin
						// nack: released until the next start
						state    <= S_WAIT;
						o_sda_oe <= 1'b0;
					end
				end
				default: begin // idle and wait both sit out until a start
					state    <= S_IDLE;
					o_sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// ****************************************************
	// programming cycle
	// ****************************************************
	// bytes beyond sixteen find the buffer full and are dropped
	page_fifo #(
		.W     (`FIFO_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_flush (flush),
		.i_valid (fifo_push),
		.o_ready (),
		.i_data  (fifo_din),
		.o_valid (fifo_valid),
		.i_ready (o_busy),
		.o_data  (fifo_dout)
	);

	always @(posedge i_clk)
		if (o_busy && fifo_valid)
			mem[fifo_dout[18:8]] <= fifo_dout[7:0];

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy   <= 1'b0;
			wr_timer <= 18'h00000;
		end else if (o_busy) begin
			// fixed cycle length, far longer than the drain itself
			if (wr_timer >= WR_CYCLES - 1)
				o_busy <= 1'b0;
			wr_timer <= wr_timer + 18'h00001;
		end else if (stop && wr_seen && fifo_valid) begin
			o_busy   <= 1'b1;
			wr_timer <= 18'h00000;
		end
	end
endmodule // eeprom_slave

// ---- src/eeprom_slave_regs.vh ----
// constants for the two-wire eeprom slave access block
// assumes a 25 MHz system clock and pins sampled through two flip-flops
`ifndef EEPROM_SLAVE_REGS_VH
`define EEPROM_SLAVE_REGS_VH

// device-type code, value arbitrary
`define DEV_TYPE        4'h5
`define ADDR_W          11
`define MEM_WORDS       2048
`define PAGE_BITS       4
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define FIFO_W          19

// timing
`define CLK_NS          40
`define WR_TIME_MS      10
`define WR_CYCLES       ((`WR_TIME_MS * 1000000) / `CLK_NS)

`endif

// ---- tb/eeprom_slave_checker.sv ----
// port assertions for the two-wire eeprom slave
// assumes the bind at the foot reaches every instance
`timescale 1ns/1ps
module eeprom_slave_checker #(
	parameter WR_CYCLES = 20
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_scl,
	input wire i_sda,
	input wire o_sda,
	input wire o_sda_oe,
	input wire i_write_protect_pin,
	input wire o_busy
);
	reg [31:0] run;
	// counts busy cycles, the figure is too long for a repetition
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			run <= 32'h0;
		else
			run <= o_busy ? run + 32'h1 : 32'h0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_pin_low_only: assert property (o_sda == 1'b0)
		else $error("sda driven high");
	a_busy_length: assert property ($fell(o_busy) |-> run == WR_CYCLES)
		else $error("busy length wrong");
	a_busy_wp_low: assert property ($rose(o_busy) |-> !i_write_protect_pin)
		else $error("write while protected");
	a_busy_after_stop: assert property
		($rose(o_busy) |-> i_scl && i_sda && !$past(i_sda, 7))
		else $error("busy without stop");
	a_busy_no_ack: assert property (o_busy |-> !o_sda_oe)
		else $error("ack while busy");
	a_ack_whole_bit: assert property ($rose(o_sda_oe) |-> o_sda_oe[*6])
		else $error("sda pull too short");
	a_bit_steady: assert property
		($rose(i_scl) |=> $stable(o_sda_oe)[*2])
		else $error("sda moved with scl high");
	a_quiet_reset: assert property ($fell(i_rst) |-> !o_sda_oe[*4])
		else $error("sda pulled after reset");
endmodule // eeprom_slave_checker

bind eeprom_slave eeprom_slave_checker #(.WR_CYCLES(WR_CYCLES)) chk (.*);

// ---- tb/two_wire_host.sv ----
// bus master model: drives scl, pulls sda low
// assumes the bench resolves sda from both pull-downs
`timescale 1ns/1ps
module two_wire_host (
	input  wire i_clk,
	input  wire i_sda,
	output reg  o_scl,
	output reg  o_sda_oe
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task q;
		repeat (2) @(posedge i_clk);
	endtask
	task start;
		begin
			o_sda_oe <= 1'b0;
			// extra wait: slave ack release must land before scl rises
			repeat (2) q;
			o_scl <= 1'b1;
			q;
			o_sda_oe <= 1'b1;
			q;
			o_scl <= 1'b0;
			q;
		end
	endtask
	task sbit(input b, output r);
		begin
			o_sda_oe <= !b;
			q;
			o_scl <= 1'b1;
			repeat (2) q;
			r = i_sda;
			o_scl <= 1'b0;
			q;
		end
	endtask
	task xfer(input [7:0] d, input a, output [7:0] r, output k);
		integer i;
		reg b;
		begin
			for (i = 7; i >= 0; i--) begin
				sbit(d[i], b);
				r[i] = b;
			end
			sbit(a, k);
		end
	endtask
	task stop;
		begin
			o_sda_oe <= 1'b1;
			q;
			o_scl <= 1'b1;
			q;
			o_sda_oe <= 1'b0;
			repeat (3) q;
		end
	endtask
endmodule // two_wire_host

// ---- tb/eeprom_slave_tb.sv ----
// self-checking bench for the two-wire eeprom slave
// assumes the host model and the bound checker
`timescale 1ns/1ps
module eeprom_slave_tb;
	reg         i_clk = 1'b0;
	reg         i_rst = 1'b1;
	reg         wp = 1'b0;
	reg         mode = 1'b0;
	reg  [2:0]  pins = 3'h0;
	wire        scl, m_oe, d_oe, busy;
	wire        sda = !(d_oe | m_oe);
	reg  [7:0]  mem [0:2047];
	reg  [31:0] seed = 32'hBB7A;
	reg  [7:0]  r;
	reg         k;
	integer     bad_count = 0;
	integer     cmp_count = 0;
	integer     i;
	always #20 i_clk = !i_clk;
	eeprom_slave #(.WR_CYCLES(200)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(d_oe),
		.i_write_protect_pin(wp), .i_chip_select_mode(mode),
		.i_chip_select_pin2(pins[2]), .i_chip_select_pin1(pins[1]),
		.i_chip_select_pin0(pins[0]), .o_busy(busy));
	two_wire_host m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(m_oe));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task complete_run;
		begin
			if (bad_count == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input string n, input [7:0] e, input [7:0] s);
		begin
			cmp_count++;
			if (s !== e) begin
				bad_count++;
				$display("CHECK FAILED %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task sad(input [7:0] a, input e);
		begin
			m.start;
			m.xfer(a, 1'b1, r, k);
			chk("ack", !e, k);
		end
	endtask
	task wb(input [7:0] d);
		begin
			m.xfer(d, 1'b1, r, k);
			chk("ack", 0, k);
		end
	endtask
	task rd(input n, input [7:0] e);
		begin
			m.xfer(8'hFF, n, r, k);
			chk("data", e, r);
		end
	endtask
	task fin(input e);
		integer n;
		begin
			m.stop;
			chk("busy", e, busy);
			for (n = 0; n < 400 && busy !== 1'b0; n++)
				@(posedge i_clk);
			if (busy !== 1'b0) begin
				bad_count++;
				complete_run;
			end
		end
	endtask
	initial begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		sad(8'h56, 1);
		wb(8'h4A);
		for (i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			mem[{3'h3, 4'h4, 4'hA + i[3:0]}] = seed[7:0];
			wb(seed[7:0]);
		end
		fin(1);
		sad(8'h56, 1);
		wb(8'h40);
		sad(8'h57, 1);
		for (i = 0; i < 15; i++)
			rd(i == 14, mem[11'h340 + i]);
		fin(0);
		sad(8'h57, 1);
		rd(1, mem[11'h34F]);
		fin(0);
		wp <= 1'b1;
		sad(8'h56, 1);
		wb(8'h45);
		wb(8'h00);
		fin(0);
		wp <= 1'b0;
		sad(8'h56, 1);
		wb(8'h45);
		sad(8'h57, 1);
		rd(1, mem[11'h345]);
		fin(0);
		sad(8'h56, 1);
		wb(8'h47);
		seed = lfsr(seed);
		mem[11'h347] = seed[7:0];
		wb(seed[7:0]);
		// address sent while programming must go unanswered
		m.stop;
		chk("busy", 1, busy);
		sad(8'h57, 0);
		fin(1);
		sad(8'h57, 1);
		rd(1, mem[11'h347]);
		fin(0);
		sad(8'h67, 0);
		fin(0);
		sad(8'h5E, 1);
		wb(8'hFF);
		seed = lfsr(seed);
		mem[11'h7FF] = seed[7:0];
		mem[11'h000] = seed[15:8];
		wb(seed[7:0]);
		fin(1);
		sad(8'h50, 1);
		wb(8'h00);
		wb(seed[15:8]);
		fin(1);
		sad(8'h5E, 1);
		wb(8'hFF);
		sad(8'h5F, 1);
		rd(0, mem[11'h7FF]);
		rd(1, mem[11'h000]);
		fin(0);
		seed = lfsr(seed);
		mode <= 1'b1;
		pins <= seed[2:0];
		sad({4'h5, seed[2:0] ^ 3'h5, 1'b0}, 0);
		fin(0);
		sad({4'h5, seed[2:0], 1'b0}, 1);
		wb(8'h03);
		wb(8'h47);
		sad({4'h5, seed[2:0], 1'b1}, 1);
		rd(1, mem[11'h347]);
		fin(0);
		complete_run;
	end
endmodule // eeprom_slave_tb
